// File: pdeo_defines.svh
/*
 constants for the port d/e alternate-function override block.
 assumes a 10 ns system clock.
*/
`ifndef PDEO_DEFINES_SVH
`define PDEO_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PDEO_CLK_NS 10
`define PDEO_SPIKE_NS 50
`define PDEO_SPIKE_CYC ((`PDEO_SPIKE_NS + `PDEO_CLK_NS - 1) / `PDEO_CLK_NS)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDEO_LINE_IDLE 1'b1
`define PDEO_CNT_ZERO 3'h0

`endif

// File: pdeo_pkg.sv
/*
 types for the port d/e alternate-function override block.
 assumes pdeo_defines.svh is on the include path.
*/
package pdeo_pkg;
   // which function currently owns a contested pin
   typedef enum logic [2:0] {
      PDEO_OWN_PORT,
      PDEO_OWN_CMP,
      PDEO_OWN_SERIAL,
      PDEO_OWN_BUS,
      PDEO_OWN_ACO
   } pdeo_owner_t;

   typedef logic [2:0] pdeo_cnt_t;
endpackage

// File: pdeo_mux.sv
/*
 pin override logic for port d bits 3..0 and port e bits 3..0.
 assumes all pin and peripheral inputs are synchronous to clk and
 that the pad cell resolves drive, value and pull-up.
*/
`timescale 1ns/10ps
`include "pdeo_defines.svh"

module pdeo_mux (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // port register bits
   input wire logic portd_dir_bit1,
   input wire logic portd_dir_bit0,
   input wire logic portd_out_bit1,
   input wire logic portd_out_bit0,
   input wire logic porte_dir_bit3,
   input wire logic porte_dir_bit2,
   input wire logic porte_dir_bit1,
   input wire logic porte_dir_bit0,
   input wire logic porte_out_bit3,
   input wire logic porte_out_bit2,
   input wire logic porte_out_bit1,
   input wire logic porte_out_bit0,
   input wire logic global_pullup_off,
   input wire logic sleep_input_off,
   // peripheral enables
   input wire logic serial0_tx_on,
   input wire logic serial0_rx_on,
   input wire logic timer4_match_a_en,
   input wire logic timer3_match_a_en,
   input wire logic spi1_on,
   input wire logic spi_master_sel,
   input wire logic twowire_on,
   input wire logic aco_oe,
   input wire logic ext_irq_one_en,
   input wire logic ext_irq_zero_en,
   input wire logic pinchg_group_d_on,
   input wire logic pinchg_group_e_on,
   input wire logic [3:0] pinchg_mask_d,
   input wire logic [3:0] pinchg_mask_e,
   input wire logic analog7_input_off,
   input wire logic analog6_input_off,
   // peripheral output data
   input wire logic serial0_tx_pin,
   input wire logic timer4_match_a_out,
   input wire logic timer3_match_a_out,
   input wire logic spi1_serial_out_in,
   input wire logic twowire1_scl_release,
   input wire logic twowire1_sda_release,
   input wire logic acompout,
   // pad side
   input wire logic [3:0] pd_in,
   input wire logic [3:0] pe_in,
   output logic [1:0] pd_drive_en,
   output logic [1:0] pd_drive_val,
   output logic [1:0] pd_pull_en,
   output logic [3:0] pd_die,
   output logic [3:0] pe_drive_en,
   output logic [3:0] pe_drive_val,
   output logic [3:0] pe_pull_en,
   output logic [3:0] pe_die,
   // peripheral input side
   output logic serial0_rx_pin,
   output logic spi1_slave_data,
   output logic capture3_pin,
   output logic capture4_pin,
   output logic timer3_count_pin,
   output logic timer4_count_pin,
   output logic ext_irq_one,
   output logic ext_irq_zero,
   output logic [3:0] pinchg_d_in,
   output logic [3:0] pinchg_e_in,
   output logic twowire1_clock_line,
   output logic twowire1_data_line,
   // ownership status
   output pdeo_pkg::pdeo_owner_t pd1_owner,
   output pdeo_pkg::pdeo_owner_t pe0_owner
);
   import pdeo_pkg::*;

   logic [1:0] next_pd_en;
   logic [1:0] next_pd_val;
   logic [1:0] next_pd_pull;
   logic [3:0] next_pe_en;
   logic [3:0] next_pe_val;
   logic [3:0] next_pe_pull;
   logic [3:0] next_pd_die;
   logic [3:0] next_pe_die;
   logic [3:0] pc_d;
   logic [3:0] pc_e;
   logic [3:0] pe_dir;
   logic [3:0] pe_port;
   pdeo_owner_t next_pd1_owner;
   pdeo_owner_t next_pe0_owner;

   // ----------------------------------------------------------------
   // pin drive selection
   // ----------------------------------------------------------------
   assign pe_dir = {porte_dir_bit3, porte_dir_bit2,
                    porte_dir_bit1, porte_dir_bit0};
   assign pe_port = {porte_out_bit3, porte_out_bit2,
                     porte_out_bit1, porte_out_bit0};

   always_comb begin
      // plain port behaviour first
      next_pd_en = {portd_dir_bit1, portd_dir_bit0};
      next_pd_val = {portd_out_bit1, portd_out_bit0};
      next_pd_pull[1] = ~portd_dir_bit1 & portd_out_bit1 &
                        ~global_pullup_off;
      next_pd_pull[0] = ~portd_dir_bit0 & portd_out_bit0 &
                        ~global_pullup_off;
      next_pe_en = pe_dir;
      next_pe_val = pe_port;
      next_pe_pull = ~pe_dir & pe_port & {4{~global_pullup_off}};
      next_pd1_owner = PDEO_OWN_PORT;
      next_pe0_owner = PDEO_OWN_PORT;
      // pd1
      if (serial0_tx_on) begin
         next_pd_en[1] = 1'b1;
         next_pd_val[1] = serial0_tx_pin;
         next_pd_pull[1] = 1'b0;
         next_pd1_owner = PDEO_OWN_SERIAL;
      end else if (timer4_match_a_en) begin
         next_pd_val[1] = timer4_match_a_out;
         next_pd1_owner = PDEO_OWN_CMP;
      end
      // pd0
      if (timer3_match_a_en) begin
         next_pd_val[0] = timer3_match_a_out;
      end
      if (serial0_rx_on) begin
         next_pd_en[0] = 1'b0;
         next_pd_pull[0] = portd_out_bit0 & ~global_pullup_off;
      end
      // pe3
      if (spi1_on && spi_master_sel) begin
         next_pe_val[3] = spi1_serial_out_in;
      end else if (spi1_on) begin
         next_pe_en[3] = 1'b0;
         next_pe_pull[3] = porte_out_bit3 & ~global_pullup_off;
      end
      // pe1 and pe0
      if (twowire_on) begin
         next_pe_en[1] = ~twowire1_scl_release;
         next_pe_val[1] = 1'b0;
         next_pe_pull[1] = 1'b0;
         next_pe_en[0] = ~twowire1_sda_release;
         next_pe_val[0] = 1'b0;
         next_pe_pull[0] = 1'b0;
         next_pe0_owner = PDEO_OWN_BUS;
      end else if (aco_oe) begin
         next_pe_en[0] = 1'b1;
         next_pe_val[0] = acompout;
         next_pe_pull[0] = 1'b0;
         next_pe0_owner = PDEO_OWN_ACO;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_drive_en <= 2'h0;
         pd_drive_val <= 2'h0;
         pd_pull_en <= 2'h0;
         pe_drive_en <= 4'h0;
         pe_drive_val <= 4'h0;
         pe_pull_en <= 4'h0;
         pd1_owner <= PDEO_OWN_PORT;
         pe0_owner <= PDEO_OWN_PORT;
      end else begin
         pd_drive_en <= next_pd_en;
         pd_drive_val <= next_pd_val;
         pd_pull_en <= next_pd_pull;
         pe_drive_en <= next_pe_en;
         pe_drive_val <= next_pe_val;
         pe_pull_en <= next_pe_pull;
         pd1_owner <= next_pd1_owner;
         pe0_owner <= next_pe0_owner;
      end
   end

   // ----------------------------------------------------------------
   // digital input enables
   // ----------------------------------------------------------------
   assign pc_d = pinchg_mask_d & {4{pinchg_group_d_on}};
   assign pc_e = pinchg_mask_e & {4{pinchg_group_e_on}};

   always_comb begin
      next_pd_die = {4{~sleep_input_off}} | pc_d;
      next_pd_die[3] = next_pd_die[3] | ext_irq_one_en;
      next_pd_die[2] = next_pd_die[2] | ext_irq_zero_en;
      next_pe_die = {4{~sleep_input_off}} | pc_e;
      if (analog7_input_off) begin
         next_pe_die[3] = pc_e[3];
      end
      if (analog6_input_off) begin
         next_pe_die[2] = pc_e[2];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_die <= 4'h0;
         pe_die <= 4'h0;
      end else begin
         pd_die <= next_pd_die;
         pe_die <= next_pe_die;
      end
   end

   // ----------------------------------------------------------------
   // peripheral input routing
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial0_rx_pin <= 1'b0;
         spi1_slave_data <= 1'b0;
         capture3_pin <= 1'b0;
         capture4_pin <= 1'b0;
         timer3_count_pin <= 1'b0;
         timer4_count_pin <= 1'b0;
         ext_irq_one <= 1'b0;
         ext_irq_zero <= 1'b0;
         pinchg_d_in <= 4'h0;
         pinchg_e_in <= 4'h0;
      end else begin
         serial0_rx_pin <= pd_in[0] & pd_die[0];
         spi1_slave_data <= pe_in[3] & pe_die[3];
         capture3_pin <= pe_in[2] & pe_die[2];
         capture4_pin <= pe_in[0] & pe_die[0];
         timer3_count_pin <= pe_in[3] & pe_die[3];
         timer4_count_pin <= pe_in[1] & pe_die[1];
         ext_irq_one <= pd_in[3] & pd_die[3];
         ext_irq_zero <= pd_in[2] & pd_die[2];
         pinchg_d_in <= pd_in & pd_die;
         pinchg_e_in <= pe_in & pe_die;
      end
   end

   // ----------------------------------------------------------------
   // two-wire spike filters
   // ----------------------------------------------------------------
   logic [1:0] twi_filt;

   assign twowire1_clock_line = twi_filt[1];
   assign twowire1_data_line = twi_filt[0];

   for (genvar g = 0; g < 2; g++) begin : g_filt
      pdeo_cnt_t cnt;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt <= `PDEO_CNT_ZERO;
            twi_filt[g] <= `PDEO_LINE_IDLE;
         end else if (!twowire_on || pe_in[g] == twi_filt[g]) begin
            cnt <= `PDEO_CNT_ZERO;
            if (!twowire_on) begin
               twi_filt[g] <= `PDEO_LINE_IDLE;
            end
         end else if (cnt == 3'(`PDEO_SPIKE_CYC - 1)) begin
            cnt <= `PDEO_CNT_ZERO;
            twi_filt[g] <= pe_in[g];
         end else begin
            cnt <= cnt + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tx_drive: assert property (
      serial0_tx_on |=> pd_drive_en[1] && !pd_pull_en[1] &&
         pd_drive_val[1] == $past(serial0_tx_pin))
      else $error("pd1 not driven by transmit data");
   a_rx_input: assert property (
      serial0_rx_on |=> !pd_drive_en[0] && pd_pull_en[0] ==
         ($past(portd_out_bit0) && !$past(global_pullup_off)))
      else $error("pd0 not forced to input");
   a_cmp_route: assert property (
      !serial0_tx_on && timer4_match_a_en |=>
         pd_drive_val[1] == $past(timer4_match_a_out) &&
         pd_drive_en[1] == $past(portd_dir_bit1))
      else $error("timer4 compare not on pd1");
   a_cmp_wave: assert property (
      timer3_match_a_en ##1 (timer3_match_a_en &&
         $changed(timer3_match_a_out)) |=> $changed(pd_drive_val[0]))
      else $error("pd0 does not follow compare waveform");
   a_pinchg_d: assert property (
      pinchg_group_d_on && pinchg_mask_d[1] |=> pd_die[1])
      else $error("pd1 input disabled under pin change");
   a_ext_irq: assert property (
      ext_irq_one_en || ext_irq_zero_en |=> (pd_die[3] ||
         !$past(ext_irq_one_en)) && (pd_die[2] || !$past(ext_irq_zero_en)))
      else $error("external irq input disabled");
   a_spi_slave: assert property (
      spi1_on && !spi_master_sel |=> !pe_drive_en[3] &&
         pe_pull_en[3] == ($past(porte_out_bit3) &&
         !$past(global_pullup_off)))
      else $error("pe3 not input in spi slave");
   a_spi_master: assert property (
      spi1_on && spi_master_sel |=> pe_drive_en[3] ==
         $past(porte_dir_bit3) &&
         pe_drive_val[3] == $past(spi1_serial_out_in))
      else $error("pe3 not spi master output");
   a_scl_drain: assert property (
      twowire_on |=> !pe_drive_val[1] && !pe_pull_en[1] &&
         pe_drive_en[1] == !$past(twowire1_scl_release))
      else $error("pe1 not open drain clock");
   a_sda_drain: assert property (
      twowire_on |=> !pe_drive_val[0] && !pe_pull_en[0] &&
         pe_drive_en[0] == !$past(twowire1_sda_release))
      else $error("pe0 not open drain data");
   a_spike_block: assert property (
      twowire_on [*6] ##0 $fell(twowire1_clock_line) |->
         !$past(pe_in[1], 1) && !$past(pe_in[1], 2) &&
         !$past(pe_in[1], 3) && !$past(pe_in[1], 4) &&
         !$past(pe_in[1], 5))
      else $error("clock line changed on short pulse");
   a_aco_drive: assert property (
      !twowire_on && aco_oe |=> pe_drive_en[0] &&
         pe_drive_val[0] == $past(acompout))
      else $error("comparator output not on pe0");
   a_capture_map: assert property (
      pe_die[2] && pe_die[0] |=> capture3_pin == $past(pe_in[2]) &&
         capture4_pin == $past(pe_in[0]))
      else $error("capture inputs misrouted");
   a_count_map: assert property (
      pe_die[3] && pe_die[1] |=> timer3_count_pin == $past(pe_in[3])
         && timer4_count_pin == $past(pe_in[1]))
      else $error("count inputs misrouted");
   a_adc_off: assert property (
      analog7_input_off && !pc_e[3] |=> !pe_die[3])
      else $error("pe3 input left on for adc");
   a_pinchg_e: assert property (
      pinchg_group_e_on && pinchg_mask_e[3] |=> pe_die[3])
      else $error("pe3 input disabled under pin change");
   a_bus_first: assert property (
      twowire_on && aco_oe |=> pe0_owner == PDEO_OWN_BUS &&
         !pe_drive_val[0])
      else $error("comparator beat the bus on pe0");
endmodule

// File: pdeo_pad_model.sv
/*
 pad model for one four-pin port: resolves each pin level from the
 block's drive, an external driver and the pull-up.
 assumes the block's drive outputs are registered on clk.
*/
`timescale 1ns/10ps
module pdeo_pad_model (
   // clock
   input wire logic clk,
   // block side
   input wire logic [3:0] drive_en,
   input wire logic [3:0] drive_val,
   input wire logic [3:0] pull_en,
   // far side
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_val,
   output logic [3:0] level
);
   // ----------------------------------------------------------------
   // floating pins change every cycle
   // ----------------------------------------------------------------
   logic [3:0] wander = 4'h5;
   always_ff @(posedge clk) begin
      wander <= ~wander;
   end
   assign level = (drive_en & drive_val)
      | (~drive_en & ext_en & ext_val)
      | (~drive_en & ~ext_en & (pull_en | wander));
endmodule

// File: testbench.sv
/*
 self-checking bench for the port d/e override block.
 assumes pdeo_pkg, pdeo_mux and pdeo_pad_model are compiled first.
*/
`timescale 1ns/10ps
module testbench import pdeo_pkg::*;;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk, rst_n, portd_dir_bit1, portd_dir_bit0;
   logic portd_out_bit1, portd_out_bit0, porte_dir_bit3, porte_dir_bit2;
   logic porte_dir_bit1, porte_dir_bit0, porte_out_bit3, porte_out_bit2;
   logic porte_out_bit1, porte_out_bit0, global_pullup_off;
   logic sleep_input_off, serial0_tx_on, serial0_rx_on, spi1_on;
   logic timer4_match_a_en, timer3_match_a_en, spi_master_sel, acompout;
   logic twowire_on, aco_oe, ext_irq_one_en, ext_irq_zero_en;
   logic pinchg_group_d_on, pinchg_group_e_on, analog7_input_off;
   logic analog6_input_off, serial0_tx_pin, timer4_match_a_out;
   logic timer3_match_a_out, spi1_serial_out_in, twowire1_scl_release;
   logic twowire1_sda_release, serial0_rx_pin, spi1_slave_data;
   logic capture3_pin, capture4_pin, timer3_count_pin, timer4_count_pin;
   logic ext_irq_one, ext_irq_zero, twowire1_clock_line;
   logic twowire1_data_line;
   logic [1:0] pd_drive_en, pd_drive_val, pd_pull_en;
   logic [3:0] pinchg_mask_d, pinchg_mask_e, pd_in, pe_in, pd_die, pe_die;
   logic [3:0] pe_drive_en, pe_drive_val, pe_pull_en, pinchg_d_in;
   logic [3:0] pinchg_e_in, pd_ext_en, pd_ext_val, pe_ext_en, pe_ext_val;
   pdeo_owner_t pd1_owner, pe0_owner;
   int mismatches, n_compared, k;
   // {controls, drive enables pd1 pd0 pe3 pe0, values}
   logic [23:0] rows [14] = '{
      24'h100188, 24'h210580,
      24'h110488, 24'h100400, 24'h120844,
      24'h220200, 24'h241000,
      24'h143022, 24'h103000,
      24'h004010, 24'h50c000,
      24'h108011, 24'h288010, 24'h2f00ff};

   pdeo_mux u_dut (.*);
   pdeo_pad_model u_pad_d (.clk(clk), .drive_en({2'h0, pd_drive_en}),
      .drive_val({2'h0, pd_drive_val}), .pull_en({2'h0, pd_pull_en}),
      .ext_en(pd_ext_en), .ext_val(pd_ext_val), .level(pd_in));
   pdeo_pad_model u_pad_e (.clk(clk), .drive_en(pe_drive_en),
      .drive_val(pe_drive_val), .pull_en(pe_pull_en),
      .ext_en(pe_ext_en), .ext_val(pe_ext_val), .level(pe_in));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apply(input logic [15:0] c);
      @(posedge clk);
      {global_pullup_off, twowire1_scl_release, twowire1_sda_release}
         <= {c[15], c[14], c[14]};
      {portd_out_bit1, portd_out_bit0, porte_out_bit3, porte_out_bit2,
         porte_out_bit1, porte_out_bit0} <= {6{c[13]}};
      {serial0_tx_pin, timer4_match_a_out, timer3_match_a_out,
         spi1_serial_out_in, acompout} <= {5{c[12]}};
      {porte_dir_bit0, porte_dir_bit3, portd_dir_bit0, portd_dir_bit1,
         aco_oe, twowire_on, spi_master_sel, spi1_on, timer3_match_a_en,
         timer4_match_a_en, serial0_rx_on, serial0_tx_on} <= c[11:0];
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #900000;
      mismatches++;
      conclude();
   end

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      mismatches = 0;
      n_compared = 0;
      {rst_n, porte_dir_bit2, porte_dir_bit1, sleep_input_off,
         ext_irq_one_en, ext_irq_zero_en, pinchg_group_d_on,
         pinchg_group_e_on, analog7_input_off, analog6_input_off,
         pinchg_mask_d, pinchg_mask_e, pd_ext_en, pd_ext_val, pe_ext_en,
         pe_ext_val, global_pullup_off, twowire1_scl_release,
         twowire1_sda_release, portd_out_bit1, portd_out_bit0,
         porte_out_bit3, porte_out_bit2, porte_out_bit1, porte_out_bit0,
         serial0_tx_pin, timer4_match_a_out, timer3_match_a_out,
         spi1_serial_out_in, acompout, porte_dir_bit0, porte_dir_bit3,
         portd_dir_bit0, portd_dir_bit1, aco_oe, twowire_on,
         spi_master_sel, spi1_on, timer3_match_a_en, timer4_match_a_en,
         serial0_rx_on, serial0_tx_on} = '0;
      repeat (4) @(posedge clk);
      #1;
      chk("reset", 8'h03, {pd_drive_en, pe_drive_en, twowire1_clock_line,
         twowire1_data_line});
      chk("reset owner", 8'h01, {7'h00, pd1_owner === PDEO_OWN_PORT});
      @(posedge clk);
      rst_n <= 1'b1;
      $display("test reset done");
      for (k = 0; k < 14; k++) begin
         apply(rows[k][23:8]);
         chk("drive", rows[k][7:0], {pd_drive_en, pe_drive_en[3],
            pe_drive_en[0], {pd_drive_val, pe_drive_val[3],
            pe_drive_val[0]} & rows[k][7:4]});
      end
      $display("test table done");
      apply(16'h2005);
      chk("tx owner", 8'h01, {7'h00, pd1_owner === PDEO_OWN_SERIAL});
      chk("tx pull", 8'h00, {7'h00, pd_pull_en[1]});
      apply(16'h2202);
      chk("rx pull", 8'h01, {7'h00, pd_pull_en[0]});
      apply(16'ha202);
      chk("rx pull off", 8'h00, {7'h00, pd_pull_en[0]});
      apply(16'h2410);
      chk("spi pull", 8'h01, {7'h00, pe_pull_en[3]});
      apply(16'h3208);
      @(posedge clk);
      timer3_match_a_out <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("pwm follow", 8'h00, {7'h00, pd_drive_val[0]});
      $display("test pull done");
      apply(16'h0000);
      @(posedge clk);
      sleep_input_off <= 1'b1;
      {pinchg_group_d_on, pinchg_group_e_on} <= 2'h3;
      {pinchg_mask_d, pinchg_mask_e, ext_irq_one_en, ext_irq_zero_en}
         <= 10'h04b;
      repeat (2) @(posedge clk);
      #1;
      chk("die d", 8'h0d, {4'h0, pd_die});
      chk("die e", 8'h02, {4'h0, pe_die});
      @(posedge clk);
      sleep_input_off <= 1'b0;
      {analog7_input_off, analog6_input_off, pinchg_mask_e} <= 6'h34;
      repeat (2) @(posedge clk);
      #1;
      chk("die adc", 8'h07, {4'h0, pe_die});
      @(posedge clk);
      {analog7_input_off, analog6_input_off, ext_irq_one_en,
         ext_irq_zero_en} <= 4'h0;
      {pd_ext_en, pe_ext_en} <= 8'hff;
      $display("test input enable done");
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         {pd_ext_val, pe_ext_val} <= k ? 8'h00 : 8'hff;
         repeat (3) @(posedge clk);
         #1;
         chk("routed", k ? 8'h00 : 8'hff, {capture3_pin, capture4_pin,
            timer3_count_pin, timer4_count_pin, ext_irq_one,
            ext_irq_zero, serial0_rx_pin, spi1_slave_data});
         chk("pin change", k ? 8'h00 : 8'hff, {pinchg_d_in,
            pinchg_e_in});
      end
      $display("test routing done");
      apply(16'h0040);
      chk("bus drive", 8'h30, {pe_drive_en, pe_drive_val});
      chk("bus owner", 8'h01, {7'h00, pe0_owner === PDEO_OWN_BUS});
      pe_ext_val <= 4'h3;
      apply(16'h4040);
      @(posedge clk);
      pe_ext_val <= 4'h0;
      repeat (4) @(posedge clk);
      pe_ext_val <= 4'h3;
      repeat (8) @(posedge clk);
      #1;
      chk("spike", 8'h03, {6'h00, twowire1_clock_line,
         twowire1_data_line});
      @(posedge clk);
      pe_ext_val <= 4'h0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (twowire1_clock_line !== 1'b0 && k < 9);
      chk("filter delay", 8'h01, {7'h00, k inside {5, 6}});
      chk("data line", 8'h00, {7'h00, twowire1_data_line});
      if (k > 8) begin
         conclude();
      end
      apply(16'h0000);
      chk("bus off", 8'h03, {6'h00, twowire1_clock_line,
         twowire1_data_line});
      $display("test two-wire done");
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      chk("mid reset", 8'h00, {pd_die, pe_die});
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset release", 8'hff, {pd_die, pe_die});
      $display("test mid reset done");
      conclude();
   end
endmodule
